// ---- core/lam_pkg.sv ----
package lam_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] LAM_IDX_L2_CTRL = 8'h14;
  localparam logic [7:0] LAM_IDX_R1_CTRL = 8'h15;
  localparam int         LAM_ADDR_W      = 8;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------

  localparam int LAM_CFG_BIT   = 7;  // Input configuration select bit.
  localparam int LAM_LVL_HI    = 6;  // Level field upper bit.
  localparam int LAM_LVL_LO    = 3;  // Level field lower bit.
  localparam int LAM_BIAS_BIT  = 2;  // Weak common-mode bias enable bit.

  // ----------------------------------------------------------------------
  // Level codes and reset values
  // ----------------------------------------------------------------------

  localparam logic [3:0] LAM_LVL_MAX_GAIN = 4'h8;  // Last valid code.
  localparam logic [3:0] LAM_LVL_OFF      = 4'hF;  // Input disconnected.
  localparam logic [3:0] LAM_LVL_RESET    = 4'hF;
  localparam logic       LAM_CFG_RESET    = 1'h0;
  localparam logic       LAM_BIAS_RESET   = 1'h0;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------

  localparam logic [1:0] LAM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LAM_RESP_SLVERR = 2'h2;

  // One line input's control fields.
  typedef struct packed {
    logic       input_config_select;  // 0 single-ended, 1 differential.
    logic [3:0] level;                // Attenuation code.
  } lam_line_ctrl_type;

  // Decoded drive to the analog mixer for one line input.
  typedef struct packed {
    logic       connect;      // Line feeds the left mixer.
    logic       diff;         // Fully differential configuration.
    logic [4:0] atten_half;   // Attenuation in 0.5 dB steps.
  } lam_mix_drive_type;

endpackage

// ---- core/lam_left_line_mix_regs.sv ----
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

module lam_left_line_mix_regs (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      ce,
  // AXI4-Lite write address channel.
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Mixer drive for the second left line input.
  output lam_pkg::lam_mix_drive_type     second_left_line_input_drive,
  // Mixer drive for the first right line input into the left mixer.
  output lam_pkg::lam_mix_drive_type     first_right_line_input_drive,
  // Weak common-mode bias for unselected left-channel inputs.
  output logic                           left_weak_bias_en
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Byte address of a register index.
  // Registers sit on word boundaries, so the index moves up two bits.
  function automatic logic [7:0] idx_addr(input logic [7:0] idx);
    idx_addr = {idx[5:0], 2'b00};
  endfunction

  // Decodes a level code into the mixer drive; reserved codes disconnect.
  // Reserved codes would scale past the last valid step, so they are held
  // off rather than driving an undefined attenuation.
  function automatic lam_pkg::lam_mix_drive_type decode_drive(
    input lam_pkg::lam_line_ctrl_type ctl
  );
    lam_pkg::lam_mix_drive_type drv;
    // The configuration follows the bit even while the line is off.
    drv.diff       = ctl.input_config_select;
    drv.connect    = (ctl.level <= lam_pkg::LAM_LVL_MAX_GAIN);
    // Each code step adds 1.5 dB, three half-dB units.
    drv.atten_half = drv.connect ? 5'({1'b0, ctl.level} * 5'h03)
                                 : 5'h00;
    decode_drive = drv;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------

  // Stored register fields.
  lam_pkg::lam_line_ctrl_type  l2_q, l2_d;      // Second left line fields.
  lam_pkg::lam_line_ctrl_type  r1_q, r1_d;      // First right line fields.
  logic                        bias_q, bias_d;  // Weak bias enable.

  // Registered mixer drives, decoded from the fields as they are stored.
  lam_pkg::lam_mix_drive_type  l2_drv_q, l2_drv_d;  // Line two drive.
  lam_pkg::lam_mix_drive_type  r1_drv_q, r1_drv_d;  // Right line one drive.

  // Write side: address and word are held until the response goes out.
  logic                        aw_held_q, aw_held_d;  // Write address held.
  logic [7:0]                  awaddr_q, awaddr_d;    // Held write address.
  logic                        w_held_q, w_held_d;    // Write data held.
  logic [31:0]                 wdata_q, wdata_d;      // Held write word.
  logic [3:0]                  wstrb_q, wstrb_d;      // Held byte strobes.

  // Write handshake outputs.
  logic                        awready_q, awready_d;  // Address accepted.
  logic                        wready_q, wready_d;    // Word accepted.
  logic                        bvalid_q, bvalid_d;    // Response pending.
  logic [1:0]                  bresp_q, bresp_d;      // Response code.

  // Read handshake outputs; the data is captured when the address is
  // taken, so a later write cannot tear an answer already on the bus.
  logic                        arready_q, arready_d;  // Address accepted.
  logic                        rvalid_q, rvalid_d;    // Answer pending.
  logic [31:0]                 rdata_q, rdata_d;      // Answer word.
  logic [1:0]                  rresp_q, rresp_d;      // Answer code.

  // Packed read image of each register with reserved bits at zero.
  // Reserved positions are constants, so no write can ever set them.
  logic [7:0]                  l2_byte;
  logic [7:0]                  r1_byte;

  assign l2_byte = {l2_q.input_config_select, l2_q.level, bias_q,
                    2'b00};
  assign r1_byte = {r1_q.input_config_select, r1_q.level,
                    3'b000};

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Captures write address and data in either order, performs the write
  // once both are held, answers reads one cycle after the address.
  // A write stores one cycle after its later half is taken, so the
  // response and the new drive appear at the same edge. Reads sample the
  // stored image and never touch a field, which keeps them free of side
  // effects.
  always_comb begin
    // Every next value but the two drives defaults to its register, so nothing latches.
    l2_d      = l2_q;
    r1_d      = r1_q;
    bias_d    = bias_q;
    aw_held_d = aw_held_q;
    awaddr_d  = awaddr_q;
    w_held_d  = w_held_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    awready_d = awready_q;
    wready_d  = wready_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;

    // A taken write address is held until the response goes out.
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
      awready_d = 1'b0;
    end

    // A taken write word is held until the response goes out.
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      wready_d = 1'b0;
    end

    // Both halves present: update the fields and raise the response.
    // The answer goes out one cycle after the later half is taken.
    if (aw_held_q && w_held_q && !bvalid_q) begin
      bvalid_d  = 1'b1;
      bresp_d   = lam_pkg::LAM_RESP_OKAY;
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      if (awaddr_q == idx_addr(lam_pkg::LAM_IDX_L2_CTRL)) begin
        // Only lane 0 carries the register; reserved bits are dropped.
        if (wstrb_q[0]) begin
          l2_d.input_config_select = wdata_q[lam_pkg::LAM_CFG_BIT];
          l2_d.level  = wdata_q[lam_pkg::LAM_LVL_HI:lam_pkg::LAM_LVL_LO];
          bias_d      = wdata_q[lam_pkg::LAM_BIAS_BIT];
        end
      end else if (awaddr_q == idx_addr(lam_pkg::LAM_IDX_R1_CTRL)) begin
        // This register has no bias bit; bits 2:0 are never stored.
        if (wstrb_q[0]) begin
          r1_d.input_config_select = wdata_q[lam_pkg::LAM_CFG_BIT];
          r1_d.level  = wdata_q[lam_pkg::LAM_LVL_HI:lam_pkg::LAM_LVL_LO];
        end
      end else begin
        // Unmapped address: nothing stored, error answer.
        bresp_d = lam_pkg::LAM_RESP_SLVERR;
      end
    end

    // Response taken: reopen both write channels.
    // Keeping them shut until then limits the write side to one request.
    if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
      awready_d = 1'b1;
      wready_d  = 1'b1;
    end

    // Read address taken: return the image with no effect on fields.
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = lam_pkg::LAM_RESP_OKAY;
      if (s_axi_araddr == idx_addr(lam_pkg::LAM_IDX_L2_CTRL)) begin
        // Upper lanes carry no register and read as zero.
        rdata_d = {24'h000000, l2_byte};
      end else if (s_axi_araddr == idx_addr(lam_pkg::LAM_IDX_R1_CTRL)) begin
        rdata_d = {24'h000000, r1_byte};
      end else begin
        // Unmapped address: zero data and an error answer.
        rdata_d = 32'h00000000;
        rresp_d = lam_pkg::LAM_RESP_SLVERR;
      end
    end

    // Read data taken: accept the next read address.
    if (rvalid_q && s_axi_rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end

    // Mixer drive follows the fields being stored.
    l2_drv_d = decode_drive(l2_d);
    r1_drv_d = decode_drive(r1_d);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // Holds all state; a low clock enable freezes every register except under reset.
  // With ce low only the reset branch assigns, so every register keeps its value until arst_n falls.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Fields come up with both inputs disconnected.
      l2_q.input_config_select <= lam_pkg::LAM_CFG_RESET;
      l2_q.level               <= lam_pkg::LAM_LVL_RESET;
      r1_q.input_config_select <= lam_pkg::LAM_CFG_RESET;
      r1_q.level               <= lam_pkg::LAM_LVL_RESET;
      bias_q                   <= lam_pkg::LAM_BIAS_RESET;
      // Drives match the reset fields: nothing connected.
      l2_drv_q                 <= '0;
      r1_drv_q                 <= '0;
      // Write side idle and ready to take a request.
      aw_held_q                <= 1'b0;
      awaddr_q                 <= 8'h00;
      w_held_q                 <= 1'b0;
      wdata_q                  <= 32'h00000000;
      wstrb_q                  <= 4'h0;
      awready_q                <= 1'b1;
      wready_q                 <= 1'b1;
      bvalid_q                 <= 1'b0;
      bresp_q                  <= lam_pkg::LAM_RESP_OKAY;
      // Read side idle and ready to take a request.
      arready_q                <= 1'b1;
      rvalid_q                 <= 1'b0;
      rdata_q                  <= 32'h00000000;
      rresp_q                  <= lam_pkg::LAM_RESP_OKAY;
    end else if (ce) begin
      // Fields and their decoded drives.
      l2_q      <= l2_d;
      r1_q      <= r1_d;
      bias_q    <= bias_d;
      l2_drv_q  <= l2_drv_d;
      r1_drv_q  <= r1_drv_d;
      // Write side.
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
      w_held_q  <= w_held_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      // Read side.
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Every output is a register copy; no logic sits between a flip-flop
  // and a pin.
  // Bus handshakes and answers.
  assign s_axi_awready                = awready_q;
  assign s_axi_wready                 = wready_q;
  assign s_axi_bvalid                 = bvalid_q;
  assign s_axi_bresp                  = bresp_q;
  assign s_axi_arready                = arready_q;
  assign s_axi_rvalid                 = rvalid_q;
  assign s_axi_rdata                  = rdata_q;
  assign s_axi_rresp                  = rresp_q;
  // Mixer controls.
  assign second_left_line_input_drive = l2_drv_q;
  assign first_right_line_input_drive = r1_drv_q;
  assign left_weak_bias_en            = bias_q;

endmodule

// ---- sim/lam_left_line_mix_regs_checker.sv ----
`timescale 1ns/1ps

module lam_left_line_mix_regs_checker (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire logic                       ce,
  input wire logic [7:0]                 s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_bvalid,
  input wire lam_pkg::lam_mix_drive_type second_left_line_input_drive,
  input wire lam_pkg::lam_mix_drive_type first_right_line_input_drive,
  input wire logic                       left_weak_bias_en
);
  localparam logic [7:0] L2A = {lam_pkg::LAM_IDX_L2_CTRL[5:0], 2'h0};
  localparam logic [7:0] R1A = {lam_pkg::LAM_IDX_R1_CTRL[5:0], 2'h0};
  logic [7:0] ra_q;  // Address of the read under way.
  logic [7:0] ra_d;  // Next value of the read address.

  // Captures the read address when the request is taken.
  always_comb begin
    ra_d = (ce && s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ra_q;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ra_q <= 8'h00;
    end else begin
      ra_q <= ra_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // A fresh read answer with no store at the same edge.
  sequence rd_l2;
    $rose(s_axi_rvalid) && !$rose(s_axi_bvalid) && ra_q == L2A;
  endsequence
  sequence rd_r1;
    $rose(s_axi_rvalid) && !$rose(s_axi_bvalid) && ra_q == R1A;
  endsequence

  chk_l2_connect: assert property (rd_l2 |->
    second_left_line_input_drive.connect == (s_axi_rdata[6:3] <= 4'h8))
    else $error("line two connect disagrees with level");
  chk_l2_config: assert property (rd_l2 |->
    second_left_line_input_drive.diff == s_axi_rdata[7])
    else $error("line two config disagrees with register");
  chk_atten_step: assert property (rd_l2 |->
    second_left_line_input_drive.atten_half ==
    (s_axi_rdata[6:3] <= 4'h8 ? 5'(s_axi_rdata[6:3] * 3) : 5'h00))
    else $error("line two attenuation wrong");
  chk_bias_follow: assert property (rd_l2 |->
    left_weak_bias_en == s_axi_rdata[2])
    else $error("bias output disagrees with register");
  chk_l2_reserved: assert property (rd_l2 |->
    s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("line two reserved bits not zero");
  chk_r1_fields: assert property (rd_r1 |->
    first_right_line_input_drive.diff == s_axi_rdata[7] &&
    first_right_line_input_drive.connect == (s_axi_rdata[6:3] <= 4'h8))
    else $error("right line one drive disagrees");
  chk_r1_reserved: assert property (rd_r1 |->
    s_axi_rdata[2:0] == 3'h0)
    else $error("right line one reserved bits not zero");
  chk_reset_off: assert property ($rose(arst_n) |->
    !second_left_line_input_drive.connect && !left_weak_bias_en &&
    !first_right_line_input_drive.connect)
    else $error("inputs not disconnected after reset");
  chk_read_quiet: assert property (!$stable({second_left_line_input_drive,
    first_right_line_input_drive, left_weak_bias_en}) |->
    $rose(s_axi_bvalid))
    else $error("drive changed without a write");
endmodule

bind lam_left_line_mix_regs lam_left_line_mix_regs_checker
  lam_left_line_mix_regs_checker_i (.clk(clk), .arst_n(arst_n), .ce(ce),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .second_left_line_input_drive(second_left_line_input_drive),
  .first_right_line_input_drive(first_right_line_input_drive),
  .left_weak_bias_en(left_weak_bias_en));

// ---- sim/lam_left_line_mix_regs_tb_top.sv ----
`timescale 1ns/1ps

module lam_left_line_mix_regs_tb_top;
  localparam logic [7:0] L2 = {lam_pkg::LAM_IDX_L2_CTRL[5:0], 2'h0};
  localparam logic [7:0] R1 = {lam_pkg::LAM_IDX_R1_CTRL[5:0], 2'h0};
  localparam logic [1:0] OK = lam_pkg::LAM_RESP_OKAY;
  logic                       clk, arst_n, ce, awv, wv, bry, arv, rry;
  logic                       awr, wr, bv, arr, rv, bias;
  logic [7:0]                 awa, ara;
  logic [31:0]                wd, rdat;
  logic [3:0]                 ws;
  logic [1:0]                 br, rr;
  lam_pkg::lam_mix_drive_type l2_drv, r1_drv;
  int                         fails, n_compared;

  lam_left_line_mix_regs lam_left_line_mix_regs_i (.clk(clk),
    .arst_n(arst_n), .ce(ce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .second_left_line_input_drive(l2_drv),
    .first_right_line_input_drive(r1_drv), .left_weak_bias_en(bias));

  always #20 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Mixer drive that a control field should produce.
  function automatic logic [31:0] drv_exp(input logic c, input logic [3:0] l);
    return {25'h0, l <= 4'h8, c, l <= 4'h8 ? 5'(l * 3) : 5'h00};
  endfunction

  // Write one word; address and data are released as each is taken.
  task automatic wrr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    b_hs = 1'b0;
    for (int n = 0; n < 50 && !b_hs; n++) begin
      @(negedge clk);
      aw_hs = awv && awr;
      w_hs = wv && wr;
      b_hs = bv && bry;
      if (b_hs) chk("bresp", 32'(br), 32'(er));
      @(posedge clk);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      if (b_hs) bry <= 1'b0;
    end
    if (!b_hs) begin
      chk("b_timeout", 32'h0, 32'h1);
      tally_and_finish;
    end
  endtask

  // Read one word and compare the response code.
  task automatic rdr(input logic [7:0] a, input logic [1:0] er,
                     output logic [31:0] v);
    logic ar_hs, r_hs;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    r_hs = 1'b0;
    for (int n = 0; n < 50 && !r_hs; n++) begin
      @(negedge clk);
      ar_hs = arv && arr;
      r_hs = rv && rry;
      v = rdat;
      if (r_hs) chk("rresp", 32'(rr), 32'(er));
      @(posedge clk);
      if (ar_hs) arv <= 1'b0;
      if (r_hs) rry <= 1'b0;
    end
    if (!r_hs) begin
      chk("r_timeout", 32'h0, 32'h1);
      tally_and_finish;
    end
  endtask

  // Both registers come up with the inputs disconnected.
  task automatic t_reset;
    logic [31:0] v;
    rdr(L2, OK, v);
    chk("l2_reset", v, 32'h78);
    rdr(R1, OK, v);
    chk("r1_reset", v, 32'h78);
    chk("reset_drv", 32'({l2_drv, r1_drv, bias}), 32'h0);
  endtask

  // Every valid level code and the off code; line two upper lanes written as ones.
  task automatic t_codes;
    logic [31:0] v;
    logic [3:0] c;
    for (int i = 0; i < 10; i++) begin
      c = (i < 9) ? 4'(i) : 4'hF;
      wrr(L2, {24'hFFFFFF, i[0], c, i[1], 2'h0}, 4'hF, OK);
      wrr(R1, {24'h0, ~i[0], c, 3'h0}, 4'h1, OK);
      rdr(L2, OK, v);
      chk("l2_image", v, {24'h0, i[0], c, i[1], 2'h0});
      chk("l2_drive", 32'(l2_drv), drv_exp(i[0], c));
      chk("bias", 32'(bias), 32'(i[1]));
      rdr(R1, OK, v);
      chk("r1_image", v, {24'h0, ~i[0], c, 3'h0});
      chk("r1_drive", 32'(r1_drv), drv_exp(~i[0], c));
    end
  endtask

  // Unmapped place, lane-0 strobe off, and repeated reads.
  task automatic t_refuse;
    logic [31:0] v;
    wrr(8'h58, 32'hFF, 4'hF, lam_pkg::LAM_RESP_SLVERR);
    rdr(8'h58, lam_pkg::LAM_RESP_SLVERR, v);
    chk("unmapped_data", v, 32'h0);
    wrr(L2, 32'h04, 4'h0, OK);
    rdr(L2, OK, v);
    chk("l2_kept", v, 32'hF8);
    rdr(L2, OK, v);
    chk("l2_reread", v, 32'hF8);
    chk("l2_drv_kept", 32'(l2_drv), drv_exp(1'b1, 4'hF));
  endtask

  initial begin
    {clk, arst_n, awv, wv, bry, arv, rry, awa, ara, wd, ws} = '0;
    ce = 1'b1;
    fails = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_codes;
    t_refuse;
    tally_and_finish;
  end
endmodule
